// ---- shared/int_map_pkg.sv ----
// Purpose: constants for the interrupt source to vector map
// Assumes: 64 requests, 44 vectors, plain register port with 32-bit words
// Notes: register offsets are word indices on the plain port
package int_map_pkg;
  localparam int num_requests = 64;
  localparam int num_vectors = 44;
  localparam int num_prio_regs = 11;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] addr_flag_0 = 8'h00;
  localparam logic [7:0] addr_flag_1 = 8'h01;
  localparam logic [7:0] addr_enable_0 = 8'h02;
  localparam logic [7:0] addr_enable_1 = 8'h03;
  localparam logic [7:0] addr_prio_base = 8'h04;
  localparam logic [7:0] addr_active = 8'h10;
  localparam logic [7:0] addr_present_0 = 8'h11;
  localparam logic [7:0] addr_present_1 = 8'h12;
  localparam logic [7:0] addr_irq_status = 8'h13;
  localparam logic [7:0] addr_irq_clear = 8'h14;
  localparam logic [7:0] addr_irq_enable = 8'h15;
  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int prio_lsb = 2;
  localparam int sub_lsb = 0;
  localparam int field_stride = 8;
  localparam logic [31:0] prio_reg_mask = 32'h1f1f1f1f;
  localparam logic [31:0] reset_word = 32'h00000000;
  localparam logic [2:0] prio_disabled = 3'h0;
  // ----------------------------------------------------------------
  // request to vector map, natural order: request 0 highest
  // ----------------------------------------------------------------
  localparam logic [5:0] vector_of [num_requests] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h05, 6'h06,
    6'h07, 6'h08, 6'h09, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d,
    6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h11, 6'h12, 6'h13,
    6'h14, 6'h15, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a,
    6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h1f, 6'h1f, 6'h20,
    6'h20, 6'h20, 6'h21, 6'h21, 6'h21, 6'h22, 6'h22, 6'h22,
    6'h23, 6'h23, 6'h24, 6'h24, 6'h24, 6'h25, 6'h25, 6'h25,
    6'h26, 6'h26, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2a, 6'h2b};
  // persistent sources: capture, converter, usb, spi, uart, i2c, change, pmp, charge_measure_request
  localparam logic [63:0] persistent_mask = 64'h0fff_fff8_1631_8c60;
  // sources that the variant carries; absent ones read zero and never set
  localparam logic [63:0] present_mask_default = 64'hffff_ffff_ffff_ffff;
  typedef enum logic [1:0] {
    sel_idle = 2'b00,
    sel_hold = 2'b01
  } sel_state_t;
endpackage

// ---- design/interrupt_source_vector_map.sv ----
// Purpose: flag, enable and priority registers for 64 requests mapped onto 44 vectors
// Assumes: requests are level inputs synchronous to sys_clk
// Notes: selection result is registered; the core sees it one cycle after a change
//   word map on the register port:
//   0x00 flag word 0, requests 0 to 31
//   0x01 flag word 1, requests 32 to 63
//   0x02 enable word 0, 0x03 enable word 1
//   0x04 to 0x0e priority words, four vectors each
//   0x10 active vector: vector 5:0, priority 8:6, sub 10:9, pending 16
//   0x11 and 0x12 present masks of this variant, read only
//   0x13 event status, read only, sticky
//   0x14 event clear, write only, a one clears
//   0x15 event enable
//   unmapped reads return zero and unmapped writes are dropped
//   a flag write stores the word; a set in the same cycle still wins
//   priority zero leaves a vector out of selection
//   no wait states; read data stand one cycle after the strobe
//
// The address-and-strobe port and the address map were left to the implementer.
module interrupt_source_vector_map #(
  parameter logic [63:0] present_mask = int_map_pkg::present_mask_default
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [63:0] req_level,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic int_pending,
  output logic [5:0] int_vector,
  output logic [2:0] int_priority,
  output logic [1:0] int_subpriority,
  output logic irq
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [63:0] flag_q;
  logic [63:0] enable_q;
  logic [31:0] prio_q [int_map_pkg::num_prio_regs];
  logic [63:0] req_prev_q;
  logic [2:0] evt_status_q;
  logic [2:0] evt_enable_q;
  logic [5:0] last_vector_q;
  int_map_pkg::sel_state_t sel_q;
  logic [63:0] flag_set;
  logic [63:0] flag_wr_val;
  logic [63:0] cand_live;
  logic [4:0] cand_key [int_map_pkg::num_requests];
  logic [31:0] rd_word;
  logic [31:0] active_word;
  logic prio_range;
  logic wr_flag_0;
  logic wr_flag_1;
  logic wr_enable_0;
  logic wr_enable_1;
  logic wr_evt_clear;
  logic wr_evt_enable;
  logic [2:0] vec_prio [int_map_pkg::num_vectors];
  logic [1:0] vec_sub [int_map_pkg::num_vectors];
  logic best_found;
  logic [5:0] best_vec;
  logic [2:0] best_prio;
  logic [1:0] best_sub;
  logic [2:0] evt_now;
  logic prio_wr_hit;
  logic [3:0] prio_idx;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // one decode per word keeps the register processes free of address compares;
  // prio_idx is only used while prio_range holds, so it never leaves the array
  assign prio_idx = 4'(reg_addr - int_map_pkg::addr_prio_base);
  assign prio_range = reg_addr >= int_map_pkg::addr_prio_base
    && reg_addr < int_map_pkg::addr_prio_base + 8'(int_map_pkg::num_prio_regs);
  assign prio_wr_hit = reg_wr && prio_range;
  assign wr_flag_0 = reg_wr && reg_addr == int_map_pkg::addr_flag_0;
  assign wr_flag_1 = reg_wr && reg_addr == int_map_pkg::addr_flag_1;
  assign wr_enable_0 = reg_wr && reg_addr == int_map_pkg::addr_enable_0;
  assign wr_enable_1 = reg_wr && reg_addr == int_map_pkg::addr_enable_1;
  assign wr_evt_clear = reg_wr && reg_addr == int_map_pkg::addr_irq_clear;
  assign wr_evt_enable = reg_wr && reg_addr == int_map_pkg::addr_irq_enable;


  // ----------------------------------------------------------------
  // flag set sources
  // ----------------------------------------------------------------
  // edge sources latch on the rising edge; level sources keep reasserting
  genvar gi;
  generate
    for (gi = 0; gi < int_map_pkg::num_requests; gi++)
    begin : g_src
      if (!present_mask[gi])
      begin : g_absent
        // the variant lacks this source, so no set logic is built for it
        assign flag_set[gi] = 1'b0;
      end
      else if (int_map_pkg::persistent_mask[gi])
      begin : g_persist
        assign flag_set[gi] = req_level[gi];
      end
      else
      begin : g_pulse
        assign flag_set[gi] = req_level[gi] && !req_prev_q[gi];
      end
    end
  endgenerate

  // cleared on reset, so a level already high after reset counts as an edge
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      req_prev_q <= '0;
    else
      req_prev_q <= req_level;
  end

  // ----------------------------------------------------------------
  // flag and enable words
  // ----------------------------------------------------------------
  // the written word replaces the flags; the set term is ored in below
  always_comb
  begin
    flag_wr_val = flag_q;
    if (wr_flag_0)
    begin
      flag_wr_val[31:0] = reg_wdata;
    end
    if (wr_flag_1)
    begin
      flag_wr_val[63:32] = reg_wdata;
    end
  end

  // a set arriving with a software clear wins, so no event is lost
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      flag_q <= '0;
    else
      flag_q <= (flag_wr_val | flag_set) & present_mask;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      enable_q <= '0;
    else if (wr_enable_0)
      enable_q[31:0] <= reg_wdata & present_mask[31:0];
    else if (wr_enable_1)
      enable_q[63:32] <= reg_wdata & present_mask[63:32];
  end

  // ----------------------------------------------------------------
  // priority words
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < int_map_pkg::num_prio_regs; i++)
        prio_q[i] <= int_map_pkg::reset_word;
    end
    else if (prio_wr_hit)
      prio_q[prio_idx] <= reg_wdata & int_map_pkg::prio_reg_mask;
  end

  // spare bits are not stored, so each vector reads only its two fields
  generate
    for (gi = 0; gi < int_map_pkg::num_vectors; gi++)
    begin : g_vec
      localparam int w = gi / 4;
      localparam int b = (gi % 4) * int_map_pkg::field_stride;
      assign vec_prio[gi] = prio_q[w][b + int_map_pkg::prio_lsb +: 3];
      assign vec_sub[gi] = prio_q[w][b + int_map_pkg::sub_lsb +: 2];
    end
  endgenerate

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  // each request carries the key of the vector that it shares; priority
  // zero leaves it out, as the core never takes such a vector
  generate
    for (gi = 0; gi < int_map_pkg::num_requests; gi++)
    begin : g_cand
      localparam logic [5:0] vn = int_map_pkg::vector_of[gi];
      assign cand_live[gi] = flag_q[gi] && enable_q[gi]
        && vec_prio[vn] != int_map_pkg::prio_disabled;
      assign cand_key[gi] = {vec_prio[vn], vec_sub[vn]};
    end
  endgenerate

  // scan from highest request number down so the lowest number wins ties;
  // one comparator per request is cheap at this clock rate
  always_comb
  begin
    best_found = 1'b0;
    best_vec = '0;
    best_prio = '0;
    best_sub = '0;
    for (int n = int_map_pkg::num_requests - 1; n >= 0; n--)
    begin
      if (cand_live[n] && (!best_found || cand_key[n] >= {best_prio, best_sub}))
      begin
        best_found = 1'b1;
        best_vec = int_map_pkg::vector_of[n];
        best_prio = cand_key[n][4:2];
        best_sub = cand_key[n][1:0];
      end
    end
  end

  // registered so the core sees one settled vector for a whole cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      int_pending <= 1'b0;
      int_vector <= '0;
      int_priority <= '0;
      int_subpriority <= '0;
    end
    else
    begin
      int_pending <= best_found;
      int_vector <= best_vec;
      int_priority <= best_prio;
      int_subpriority <= best_sub;
    end
  end

  // ----------------------------------------------------------------
  // status events: new request, vector change, request dropped
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sel_q <= int_map_pkg::sel_idle;
      last_vector_q <= '0;
    end
    else
    begin
      last_vector_q <= best_vec;
      // idle and hold only track whether anything is pending
      case (sel_q)
        int_map_pkg::sel_idle: if (best_found) sel_q <= int_map_pkg::sel_hold;
        int_map_pkg::sel_hold: if (!best_found) sel_q <= int_map_pkg::sel_idle;
        default: sel_q <= int_map_pkg::sel_idle;
      endcase
    end
  end

  // bit 0 pending rose, bit 1 vector moved while pending, bit 2 pending fell
  assign evt_now[0] = sel_q == int_map_pkg::sel_idle && best_found;
  assign evt_now[1] = sel_q == int_map_pkg::sel_hold && best_found
    && best_vec != last_vector_q;
  assign evt_now[2] = sel_q == int_map_pkg::sel_hold && !best_found;

  // a one clears its bit; an event in that same cycle survives the clear
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      evt_status_q <= '0;
    else if (wr_evt_clear)
      evt_status_q <= (evt_status_q & ~reg_wdata[2:0]) | evt_now;
    else
      evt_status_q <= evt_status_q | evt_now;
  end

  // enable bits only gate irq; status keeps recording while masked
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      evt_enable_q <= '0;
    else if (wr_evt_enable)
      evt_enable_q <= reg_wdata[2:0];
  end

  // a level: it drops as soon as the status bit is cleared or masked
  assign irq = |(evt_status_q & evt_enable_q);

  // ----------------------------------------------------------------
  // read port: data one cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------
  assign active_word = {15'h0000, int_pending, 5'h00, int_subpriority, int_priority,
    int_vector};

  always_comb
  begin
    rd_word = '0;
    if (prio_range)
      rd_word = prio_q[prio_idx];
    else
    begin
      case (reg_addr)
        int_map_pkg::addr_flag_0: rd_word = flag_q[31:0];
        int_map_pkg::addr_flag_1: rd_word = flag_q[63:32];
        int_map_pkg::addr_enable_0: rd_word = enable_q[31:0];
        int_map_pkg::addr_enable_1: rd_word = enable_q[63:32];
        int_map_pkg::addr_active: rd_word = active_word;
        int_map_pkg::addr_present_0: rd_word = present_mask[31:0];
        int_map_pkg::addr_present_1: rd_word = present_mask[63:32];
        int_map_pkg::addr_irq_status: rd_word = {29'h0, evt_status_q};
        int_map_pkg::addr_irq_enable: rd_word = {29'h0, evt_enable_q};
        default: rd_word = '0;
      endcase
    end
  end

  // the word is taken at the strobe edge, before any write of that edge lands
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else
      reg_rdata <= rd_word;
  end
endmodule

// ---- verification/req_sources.sv ----
// Purpose: peripheral request sources standing in front of the map
// Assumes: sources are level outputs of on-chip logic on sys_clk
// Notes: bench commands the levels; the model registers them like real peripherals
module req_sources (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [63:0] level_cmd,
  output logic [63:0] req_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // a registered stage so no request ever moves on the sampling edge
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      req_level <= 64'h0;
    else
      req_level <= level_cmd;
  end
endmodule

// ---- verification/isvm_asserts.sv ----
// Purpose: port checks for the interrupt source to vector map
// Assumes: one clock domain, synchronous active-low reset
// Notes: flag state is internal, so most checks look through register reads
module isvm_checker #(
  parameter logic [63:0] present_mask = 64'hffff_ffff_ffff_ffff
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [63:0] req_level,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic int_pending,
  input wire logic [5:0] int_vector,
  input wire logic [2:0] int_priority,
  input wire logic [1:0] int_subpriority,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence rd_at(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  pend_prio_a: assert property (int_pending |-> int_priority != 3'h0)
    else $error("pending with priority zero");
  vec_range_a: assert property (int_pending |-> int_vector < 6'h2c)
    else $error("vector out of range");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without read");
  prio_mask_a: assert property (reg_rd && reg_addr >= 8'h04 && reg_addr <= 8'h0e
    |=> (reg_rdata & ~int_map_pkg::prio_reg_mask) == 32'h0) else $error("priority spare bits");
  present_lo_a: assert property (rd_at(int_map_pkg::addr_present_0)
    |=> reg_rdata == present_mask[31:0]) else $error("present word 0");
  present_hi_a: assert property (rd_at(int_map_pkg::addr_present_1)
    |=> reg_rdata == present_mask[63:32]) else $error("present word 1");
  flag_absent_a: assert property (rd_at(int_map_pkg::addr_flag_1)
    |=> (reg_rdata & ~present_mask[63:32]) == 32'h0) else $error("absent flag set");
  enable_absent_a: assert property (rd_at(int_map_pkg::addr_enable_1)
    |=> (reg_rdata & ~present_mask[63:32]) == 32'h0) else $error("absent enable set");
  active_word_a: assert property (rd_at(int_map_pkg::addr_active)
    |=> reg_rdata[5:0] == $past(int_vector) && reg_rdata[16] == $past(int_pending))
    else $error("active word disagrees");
endmodule
bind interrupt_source_vector_map isvm_checker #(.present_mask(present_mask)) isvm_checker_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .req_level(req_level), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .int_pending(int_pending), .int_vector(int_vector), .int_priority(int_priority),
  .int_subpriority(int_subpriority), .irq(irq));

// ---- verification/test_interrupt_source_vector_map.sv ----
// Purpose: register-level tests of the interrupt source to vector map
// Assumes: plain register port, read data one cycle after the strobe
// Notes: request 35 is built absent to exercise the variant mask
module test_interrupt_source_vector_map;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] pm = 64'hffff_fff7_ffff_ffff;
  localparam int vmap [64] = '{0, 1, 2, 3, 4, 5, 5, 6, 7, 8, 9, 9, 10, 11, 12, 13, 13, 14, 15,
    16, 17, 17, 18, 19, 20, 21, 21, 22, 23, 24, 25, 26, 27, 28, 29, 30, 31, 31, 31, 32, 32, 32,
    33, 33, 33, 34, 34, 34, 35, 35, 36, 36, 36, 37, 37, 37, 38, 38, 38, 39, 40, 41, 42, 43};
  logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [63:0] lv = 64'h0, req_level, m;
  logic int_pending, irq;
  logic [5:0] int_vector;
  logic [2:0] int_priority;
  logic [1:0] int_subpriority;
  int fail_count = 0, n_checks = 0;
  always #25 sys_clk = ~sys_clk;
  req_sources req_sources_i (.sys_clk(sys_clk), .rst_n(rst_n), .level_cmd(lv),
    .req_level(req_level));
  interrupt_source_vector_map #(.present_mask(pm)) interrupt_source_vector_map_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_level(req_level), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .int_pending(int_pending), .int_vector(int_vector), .int_priority(int_priority),
    .int_subpriority(int_subpriority), .irq(irq));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // flags set by software, then the selected vector is read at the core side
  task automatic pick(input logic [31:0] w10, input logic [63:0] f, input int exp);
    wr(int_map_pkg::addr_prio_base + 8'h0a, w10);
    wr(int_map_pkg::addr_flag_0, f[31:0]);
    wr(int_map_pkg::addr_flag_1, f[63:32]);
    repeat (2) @(posedge sys_clk);
    #1 chk("vector", exp, {26'h0, int_vector});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #(50 * 8000);
    fail_count++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 15; a++)
    begin
      rd(a[7:0], d);
      chk("reset word", 32'h0, d);
    end
    rd(8'h3f, d);
    chk("unmapped", 32'h0, d);
    wr(int_map_pkg::addr_enable_0, 32'hffffffff);
    wr(int_map_pkg::addr_enable_1, 32'hffffffff);
    rd(int_map_pkg::addr_enable_0, d);
    chk("enable 0", 32'hffffffff, d);
    rd(int_map_pkg::addr_enable_1, d);
    chk("enable 1", pm[63:32], d);
    wr(int_map_pkg::addr_prio_base, 32'hffffffff);
    rd(int_map_pkg::addr_prio_base, d);
    chk("priority word", 32'h1f1f1f1f, d);
    rd(int_map_pkg::addr_present_0, d);
    chk("present 0", pm[31:0], d);
    rd(int_map_pkg::addr_present_1, d);
    chk("present 1", pm[63:32], d);
    lv <= 64'h1000_0108_0000_0008;
    repeat (4) @(posedge sys_clk);
    rd(int_map_pkg::addr_flag_0, d);
    chk("flag 0", 32'h00000008, d);
    rd(int_map_pkg::addr_flag_1, d);
    chk("flag 1", 32'h10000100, d);
    wr(int_map_pkg::addr_flag_0, 32'h0);
    wr(int_map_pkg::addr_flag_1, 32'h0);
    rd(int_map_pkg::addr_flag_0, d);
    chk("flag 0 cleared", 32'h0, d);
    rd(int_map_pkg::addr_flag_1, d);
    chk("flag 1 cleared", 32'h00000100, d);
    lv <= 64'h0;
    for (int i = 0; i < 11; i++)
      wr(int_map_pkg::addr_prio_base + i[7:0], 32'h04040404);
    for (int n = 0; n < 64; n++)
      if (n != 35)
      begin
        m = 64'h1 << n;
        pick(32'h04040404, m, vmap[n]);
        chk("priority", 32'h1, {29'h0, int_priority});
      end
    pick(32'h08040404, 64'h8000_0000_0000_0001, 43);
    pick(32'h07040404, 64'h8000_0000_0000_0001, 43);
    pick(32'h04040404, 64'h8000_0000_0000_0080, 6);
    pick(32'h04040404, 64'h0, 0);
    chk("pending idle", 32'h0, {31'h0, int_pending});
    wr(int_map_pkg::addr_irq_clear, 32'h7);
    wr(int_map_pkg::addr_irq_enable, 32'h1);
    #1 chk("irq idle", 32'h0, {31'h0, irq});
    pick(32'h04040404, 64'h1, 0);
    rd(int_map_pkg::addr_irq_status, d);
    chk("status rose", 32'h1, d & 32'h1);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(int_map_pkg::addr_irq_enable, 32'h0);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    wr(int_map_pkg::addr_irq_enable, 32'h1);
    wr(int_map_pkg::addr_irq_clear, 32'h1);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    rd(int_map_pkg::addr_active, d);
    chk("active word", 32'h00010040, d);
    complete_run();
  end
endmodule
